// ---- intc_pkg.sv ----
// Constants, register map and state codes of the interrupt acceptance logic
package intc_pkg;
  localparam int NUM_SRC = 16;
  localparam int NUM_EXT = 6;
  localparam int IDX_W = 4;
  localparam int CNT_W = 4;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_CCR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_PRIO_A = 8'h0C;
  localparam logic [7:0] OFS_PRIO_B = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PEND = 8'h18;
  localparam logic [7:0] OFS_SAVED_PC = 8'h1C;
  localparam logic [7:0] OFS_HANDLER = 8'h20;
  // ==========================================
  // Field positions and reset values
  localparam int SYS_MODE_BIT = 0;
  localparam int SYS_MEM_LSB = 1;
  localparam int CCR_PRIM_BIT = 7;
  localparam int CCR_SEC_BIT = 6;
  localparam logic [7:0] SYSCTL_RST = 8'h01;
  localparam logic [7:0] CCR_RST = 8'h80;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [7:0] PRIO_RST = 8'h00;
  // ==========================================
  // Vector numbers
  localparam logic [7:0] NMI_VECTOR = 8'h07;
  localparam logic [7:0] SRC_VECTOR_BASE = 8'h0C;
  // ==========================================
  // Memory types and state counts
  localparam logic [1:0] MEM_ONCHIP = 2'h0;
  localparam logic [1:0] MEM_FAST16 = 2'h1;
  localparam logic [1:0] MEM_FAST8 = 2'h2;
  localparam logic [1:0] MEM_SLOW8 = 2'h3;
  localparam logic [CNT_W-1:0] DECIDE_EXT = 4'h2;
  localparam logic [CNT_W-1:0] DECIDE_INT = 4'h1;
  localparam logic [CNT_W-1:0] INTERNAL_HALF = 4'h2;
  localparam logic [CNT_W-1:0] ACC_FAST = 4'h4;
  localparam logic [CNT_W-1:0] ACC_FAST8 = 4'h8;
  localparam logic [CNT_W-1:0] ACC_SLOW8 = 4'hC;

  function automatic logic [CNT_W-1:0] access_states(input logic [1:0] mt);
    unique case (mt)
      MEM_FAST8: access_states = ACC_FAST8;
      MEM_SLOW8: access_states = ACC_SLOW8;
      default: access_states = ACC_FAST;
    endcase
  endfunction

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DECIDE = 9'h002,
    ST_DRAIN = 9'h004,
    ST_PREF1 = 9'h008,
    ST_INT1 = 9'h010,
    ST_STACK = 9'h020,
    ST_VECT = 9'h040,
    ST_PREF2 = 9'h080,
    ST_INT2 = 9'h100
  } state_type;
endpackage

// ---- prio_select.sv ----
// Fixed-order selector that prefers level-1 requests
`timescale 1ns/10ps
module prio_select
  import intc_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] req_in,
  input wire logic [N-1:0] level_in,
  output logic found_out,
  output logic high_out,
  output logic [IDX_W-1:0] index_out
);
  wire logic [N-1:0] high_req = req_in & level_in;
  wire logic [N-1:0] pool = (|high_req) ? high_req : req_in;

  assign found_out = |req_in;
  assign high_out = |high_req;

  // Lowest index is the smallest vector number and wins
  always_comb begin
    index_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pool[i]) begin
        index_out = IDX_W'(i);
      end
    end
  end
endmodule

// ---- phase_timer.sv ----
// Down counter that times one exception phase, frozen by wait states
`timescale 1ns/10ps
module phase_timer
  import intc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] value_in,
  input wire logic hold_in,
  output logic last_out
);
  logic [CNT_W-1:0] cnt;

  assign last_out = (cnt == CNT_W'(1)) && !hold_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
    end else if (load_in) begin
      cnt <= value_in;
    end else if (!hold_in && cnt != '0) begin
      cnt <= cnt - CNT_W'(1);
    end
  end
endmodule

// ---- intc_accept.sv ----
// Interrupt acceptance, masking and exception entry sequencer
// How it works
// - Mode bit 1 masks with primary bit only; mode 0 uses both bits.
// - NMI is accepted regardless of masks, except in reset and standby.
// - A source requests only while its enable bit is set.
// - Higher programmed level wins; equal levels follow fixed source order.
// - Mode 1, primary clear: accept selected request, level 1 first.
// - Mode 1, primary set: only NMI accepted, others stay pending.
// - Mode 1: after saving state, primary mask bit is set.
// - Mode 0: level-0 requests enabled only while primary bit is clear.
// - Mode 0: level-1 requests disabled only when both bits set.
// - Mode 0, primary clear: accept regardless of level and secondary bit.
// - Mode 0, primary set, secondary clear: only level-1 accepted.
// - Mode 0, both bits set: all maskable requests stay pending.
// - Mode 0: after saving state, both mask bits are set.
// - Priority decision takes 2 states external, 1 state internal.
// - Handling starts only after the current instruction completes.
// - Stack save takes 4, 8 or 12 states by memory type.
// - Prefetch takes 4, 8 or 12 states in two halves.
// - Internal processing takes 4 states in two halves.
// - External wait states stretch the memory phases.
// - Among equal levels the smaller vector number wins.
// - After reset priority settings clear, giving fixed default order.
`timescale 1ns/10ps
module intc_accept
  import intc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [NUM_SRC-1:0] src_req_in,
  input wire logic nmi_in,
  input wire logic standby_in,
  input wire logic instr_done_in,
  input wire logic [31:0] pc_in,
  input wire logic mem_wait_in,
  input wire logic [31:0] vector_data_in,
  output logic accept_out,
  output logic busy_out,
  output logic stack_push_out,
  output logic vector_fetch_out,
  output logic prefetch_out,
  output logic [31:0] vector_addr_out,
  output logic [31:0] saved_pc_out,
  output logic [7:0] saved_ccr_out,
  output logic handler_start_out,
  output logic [31:0] handler_addr_out,
  output logic primary_mask_out,
  output logic secondary_mask_out
);
  // ==========================================
  // Register bus
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = sel[b] ? dat[8*b +: 8] : old[8*b +: 8];
    end
    return old;
  endfunction

  logic [7:0] system_control_reg;
  logic [7:0] condition_code_reg;
  logic [15:0] enable_reg;
  logic [7:0] priority_setting_a;
  logic [7:0] priority_setting_b;
  logic nmi_pend;
  logic nmi_prev;
  state_type state;
  state_type next_state;
  logic win_nmi;
  logic [IDX_W-1:0] win_idx;
  logic [7:0] win_vector;

  wire logic bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic bus_wr = bus_req && wb_we_in;
  wire logic wr_sys = bus_wr && wb_adr_in == OFS_SYSCTL;
  wire logic wr_ccr = bus_wr && wb_adr_in == OFS_CCR;
  wire logic wr_en = bus_wr && wb_adr_in == OFS_ENABLE;
  wire logic wr_pa = bus_wr && wb_adr_in == OFS_PRIO_A;
  wire logic wr_pb = bus_wr && wb_adr_in == OFS_PRIO_B;
  wire logic [31:0] sys_new =
    lane_merge({24'h0, system_control_reg}, wb_dat_in, wb_sel_in);
  wire logic [31:0] ccr_new =
    lane_merge({24'h0, condition_code_reg}, wb_dat_in, wb_sel_in);
  wire logic [31:0] en_new =
    lane_merge({16'h0, enable_reg}, wb_dat_in, wb_sel_in);
  wire logic [31:0] pa_new =
    lane_merge({24'h0, priority_setting_a}, wb_dat_in, wb_sel_in);
  wire logic [31:0] pb_new =
    lane_merge({24'h0, priority_setting_b}, wb_dat_in, wb_sel_in);

  // ==========================================
  // Mask decision
  wire logic mode = system_control_reg[SYS_MODE_BIT];
  wire logic [1:0] mem_type = system_control_reg[SYS_MEM_LSB +: 2];
  wire logic prim = condition_code_reg[CCR_PRIM_BIT];
  wire logic sec = condition_code_reg[CCR_SEC_BIT];
  wire logic [NUM_SRC-1:0] level_vec = {priority_setting_b, priority_setting_a};
  wire logic [NUM_SRC-1:0] active = src_req_in & enable_reg;
  wire logic sel_found;
  wire logic sel_high;
  wire logic [IDX_W-1:0] sel_idx;

  prio_select #(
    .N(NUM_SRC)
  ) u_select (
    .req_in(active),
    .level_in(level_vec),
    .found_out(sel_found),
    .high_out(sel_high),
    .index_out(sel_idx)
  );

  // Level 1 sees both bits in mode 0, level 0 only the primary bit
  wire logic lvl0_ok = !prim;
  wire logic lvl1_ok = mode ? !prim : (!prim || !sec);
  wire logic mask_ok = sel_high ? lvl1_ok : lvl0_ok;
  wire logic maskable_go = sel_found && mask_ok;
  wire logic nmi_ok = nmi_pend && !standby_in;
  wire logic idle = state == ST_IDLE;
  wire logic go = idle && !standby_in && (nmi_ok || maskable_go);
  wire logic go_ext = nmi_ok || int'(sel_idx) < NUM_EXT;
  wire logic nmi_edge = nmi_in && !nmi_prev;
  wire logic take_nmi = go && nmi_ok;

  // ==========================================
  // Phase timing
  wire logic tmr_last;
  wire logic [CNT_W-1:0] acc_cnt = access_states(mem_type);
  wire logic [CNT_W-1:0] half_cnt = acc_cnt >> 1;
  wire logic mem_phase = state inside {ST_PREF1, ST_STACK, ST_VECT, ST_PREF2};
  wire logic ext_mem = mem_type != MEM_ONCHIP;
  wire logic tmr_hold = mem_phase && ext_mem && mem_wait_in;
  wire logic tmr_load = next_state != state;
  logic [CNT_W-1:0] tmr_value;

  always_comb begin
    unique case (next_state)
      ST_DECIDE: tmr_value = go_ext ? DECIDE_EXT : DECIDE_INT;
      ST_PREF1, ST_PREF2: tmr_value = half_cnt;
      ST_INT1, ST_INT2: tmr_value = INTERNAL_HALF;
      ST_STACK, ST_VECT: tmr_value = acc_cnt;
      default: tmr_value = '0;
    endcase
  end

  phase_timer u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .hold_in(tmr_hold),
    .last_out(tmr_last)
  );

  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (go) next_state = ST_DECIDE;
      ST_DECIDE: if (tmr_last) next_state = ST_DRAIN;
      ST_DRAIN: if (instr_done_in) next_state = ST_PREF1;
      ST_PREF1: if (tmr_last) next_state = ST_INT1;
      ST_INT1: if (tmr_last) next_state = ST_STACK;
      ST_STACK: if (tmr_last) next_state = ST_VECT;
      ST_VECT: if (tmr_last) next_state = ST_PREF2;
      ST_PREF2: if (tmr_last) next_state = ST_INT2;
      ST_INT2: if (tmr_last) next_state = ST_IDLE;
    endcase
  end

  wire logic stack_done = state == ST_STACK && tmr_last;
  wire logic vect_done = state == ST_VECT && tmr_last;
  wire logic entry_done = state == ST_INT2 && tmr_last;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Winner is frozen at go so later requests cannot disturb the entry
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      win_nmi <= 1'b0;
      win_idx <= '0;
    end else if (go) begin
      win_nmi <= nmi_ok;
      win_idx <= sel_idx;
    end
  end

  assign win_vector = win_nmi ? NMI_VECTOR : SRC_VECTOR_BASE + 8'(win_idx);

  // ==========================================
  // NMI latch, set wins over clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_prev <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      nmi_prev <= nmi_in;
      nmi_pend <= nmi_edge || (nmi_pend && !take_nmi);
    end
  end

  // ==========================================
  // Registers, hardware mask set wins over software write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      system_control_reg <= SYSCTL_RST;
      enable_reg <= ENABLE_RST;
      priority_setting_a <= PRIO_RST;
      priority_setting_b <= PRIO_RST;
    end else begin
      if (wr_sys) system_control_reg <= sys_new[7:0];
      if (wr_en) enable_reg <= en_new[15:0];
      if (wr_pa) priority_setting_a <= pa_new[7:0];
      if (wr_pb) priority_setting_b <= pb_new[7:0];
    end
  end

  logic [7:0] next_ccr;

  always_comb begin
    next_ccr = wr_ccr ? ccr_new[7:0] : condition_code_reg;
    if (stack_done) begin
      next_ccr[CCR_PRIM_BIT] = 1'b1;
      if (!mode) next_ccr[CCR_SEC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      condition_code_reg <= CCR_RST;
    end else begin
      condition_code_reg <= next_ccr;
    end
  end

  // ==========================================
  // Saved state, vector and handler
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      saved_pc_out <= '0;
      saved_ccr_out <= '0;
      vector_addr_out <= '0;
      handler_addr_out <= '0;
      handler_start_out <= 1'b0;
    end else begin
      if (state == ST_DRAIN && instr_done_in) begin
        saved_pc_out <= pc_in;
        saved_ccr_out <= condition_code_reg;
      end
      if (state == ST_DECIDE && tmr_last) vector_addr_out <= {22'h0, win_vector, 2'h0};
      if (vect_done) handler_addr_out <= vector_data_in;
      handler_start_out <= entry_done;
    end
  end

  assign accept_out = state == ST_DECIDE && tmr_last;
  assign busy_out = !idle;
  assign stack_push_out = state == ST_STACK;
  assign vector_fetch_out = state == ST_VECT;
  assign prefetch_out = state inside {ST_PREF1, ST_PREF2};
  assign primary_mask_out = prim;
  assign secondary_mask_out = sec;

  // ==========================================
  // Bus answer, one wait state, unmapped reads zero
  logic [31:0] rd_mux;

  always_comb begin
    unique case (wb_adr_in)
      OFS_SYSCTL: rd_mux = {24'h0, system_control_reg};
      OFS_CCR: rd_mux = {24'h0, condition_code_reg};
      OFS_ENABLE: rd_mux = {16'h0, enable_reg};
      OFS_PRIO_A: rd_mux = {24'h0, priority_setting_a};
      OFS_PRIO_B: rd_mux = {24'h0, priority_setting_b};
      OFS_STATUS: rd_mux = {13'h0, nmi_pend, win_nmi, win_vector, state};
      OFS_PEND: rd_mux = {16'h0, active};
      OFS_SAVED_PC: rd_mux = saved_pc_out;
      OFS_HANDLER: rd_mux = handler_addr_out;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= (bus_req && !wb_we_in) ? rd_mux : '0;
    end
  end

  // ==========================================
  // Checks
  sequence s_int1_run;
    (state == ST_INT1) [*2] ##1 (state == ST_STACK);
  endsequence

  sequence s_ext_decide;
    (state == ST_DECIDE && !accept_out) ##1 accept_out;
  endsequence

  a_nmi_taken: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (idle && nmi_pend && !standby_in) |=> (state == ST_DECIDE && win_nmi))
    else $error("pending NMI not taken");

  a_disabled_ignored: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (idle && !nmi_pend && (src_req_in & enable_reg) == '0) |=> idle)
    else $error("disabled request started entry");

  a_mode1_masked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (idle && mode && prim && !nmi_pend) |=> idle)
    else $error("maskable taken with primary mask set");

  a_mode0_both_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (idle && !mode && prim && sec && !nmi_pend) |=> idle)
    else $error("maskable taken with both masks set");

  a_level1_first: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (go && !nmi_ok && |(active & level_vec)) |=> level_vec[win_idx])
    else $error("level 0 chosen over level 1");

  a_ext_decide: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (go && go_ext) |=> s_ext_decide)
    else $error("external decision not two states");

  a_int_decide: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (go && !go_ext) |=> accept_out)
    else $error("internal decision not one state");

  a_internal_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(state == ST_INT1) |-> s_int1_run)
    else $error("internal processing not two states");

  a_mask_after_save: assert property (@(posedge clk_in) disable iff (!nrst_in)
    stack_done |=> (prim && (mode || sec)))
    else $error("mask bits not set after stack save");

  a_return_pc: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_DRAIN && instr_done_in) |=> saved_pc_out == $past(pc_in))
    else $error("saved PC is not the return address");
endmodule

// ---- cpu_model.sv ----
// Behavioural CPU core that answers the exception entry sequencer
`timescale 1ns/10ps
module cpu_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic busy_in,
  input wire logic stack_push_in,
  input wire logic vector_fetch_in,
  input wire logic [31:0] vector_addr_in,
  input wire logic [7:0] drain_len_in,
  input wire logic [3:0] wait_count_in,
  input wire logic [31:0] ret_pc_in,
  output logic instr_done_out,
  output logic [31:0] pc_out,
  output logic mem_wait_out,
  output logic [31:0] vector_data_out
);
  logic [7:0] busy_cnt;
  logic [3:0] waits_left;
  logic [31:0] handler;
  assign handler = 32'h00004000 | vector_addr_in;
  // Current instruction ends drain_len cycles into an entry
  assign instr_done_out = busy_in && (busy_cnt >= drain_len_in);
  // Return address shows only while the instruction ends
  assign pc_out = instr_done_out ? ret_pc_in : ~ret_pc_in;
  assign mem_wait_out = stack_push_in && (waits_left != 4'h0);
  // Table word is driven only during the vector fetch
  assign vector_data_out = vector_fetch_in ? handler : ~handler;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_cnt <= 8'h00;
      waits_left <= 4'h0;
    end else if (!busy_in) begin
      busy_cnt <= 8'h00;
      waits_left <= wait_count_in;
    end else begin
      if (busy_cnt != 8'hFF) busy_cnt <= busy_cnt + 8'h01;
      if (mem_wait_out) waits_left <= waits_left - 4'h1;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for interrupt acceptance and exception entry
`timescale 1ns/10ps
module testbench;
  import intc_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, ret_pc = 32'h00001000, rd;
  logic [NUM_SRC-1:0] src_req_in = '0;
  logic nmi_in = 1'b0, standby_in = 1'b0, instr_done_in, mem_wait_in;
  logic [31:0] pc_in, vector_data_in, wb_dat_out, vector_addr_out, saved_pc_out, handler_addr_out;
  logic wb_ack_out, accept_out, busy_out, stack_push_out, vector_fetch_out, prefetch_out;
  logic handler_start_out, primary_mask_out, secondary_mask_out;
  logic [7:0] saved_ccr_out, drain_len = 8'h00;
  int miscompares = 0, num_checks = 0, cycles = 0, acc_at = 0, pf = 0, lat, cyc, l_ext, m, s;

  always #4 clk_in = ~clk_in;

  intc_accept intc_accept_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .src_req_in(src_req_in),
    .nmi_in(nmi_in), .standby_in(standby_in), .instr_done_in(instr_done_in), .pc_in(pc_in),
    .mem_wait_in(mem_wait_in), .vector_data_in(vector_data_in), .accept_out(accept_out),
    .busy_out(busy_out), .stack_push_out(stack_push_out), .vector_fetch_out(vector_fetch_out),
    .prefetch_out(prefetch_out), .vector_addr_out(vector_addr_out),
    .saved_pc_out(saved_pc_out), .saved_ccr_out(saved_ccr_out),
    .handler_start_out(handler_start_out), .handler_addr_out(handler_addr_out),
    .primary_mask_out(primary_mask_out), .secondary_mask_out(secondary_mask_out));

  cpu_model cpu_model_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .busy_in(busy_out), .stack_push_in(stack_push_out),
    .vector_fetch_in(vector_fetch_out), .vector_addr_in(vector_addr_out),
    .drain_len_in(drain_len), .wait_count_in(4'h3), .ret_pc_in(ret_pc),
    .instr_done_out(instr_done_in), .pc_out(pc_in), .mem_wait_out(mem_wait_in),
    .vector_data_out(vector_data_in));

  // ==========================================
  // Checking and closing
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // Cycle stamp of the last acceptance pulse
  always @(negedge clk_in) begin
    if (accept_out === 1'b1) acc_at = cycles;
    if (prefetch_out === 1'b1) pf++;
  end

  // ==========================================
  // Bus and entry tasks
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_sel_in <= 4'hF;
    wb_dat_in <= dat;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n == 40) check_val(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h0);
    check_val(rd, exp);
  endtask

  task automatic no_accept(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      if (accept_out !== 1'b0 || busy_out !== 1'b0) seen = 1'b1;
    end
    check_val({31'h0, seen}, 32'h0);
  endtask

  // Raises requests, waits for the handler start, checks vector, handler and return address
  task automatic entry(input logic [7:0] vec, input logic [15:0] add, input logic nm);
    int n = 0;
    int start = 0;
    @(posedge clk_in);
    pf = 0;
    src_req_in <= src_req_in | add;
    nmi_in <= nm;
    standby_in <= 1'b0;
    ret_pc <= ret_pc + 32'h10;
    @(negedge clk_in);
    start = cycles;
    while (handler_start_out !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    check_val({31'h0, handler_start_out}, 32'h1);
    check_val({31'h0, acc_at != 0}, 32'h1);
    lat = acc_at - start;
    cyc = cycles - acc_at;
    check_val(vector_addr_out, {22'h0, vec, 2'b00});
    check_val(handler_addr_out, 32'h00004000 | {22'h0, vec, 2'b00});
    check_val(saved_pc_out, ret_pc);
    @(posedge clk_in);
    acc_at = 0;
    nmi_in <= 1'b0;
    if (vec >= SRC_VECTOR_BASE) src_req_in[4'(vec - SRC_VECTOR_BASE)] <= 1'b0;
  endtask

  // ==========================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk(OFS_SYSCTL, 32'h01);
    rd_chk(OFS_CCR, 32'h80);
    rd_chk(OFS_ENABLE, 32'h0);
    rd_chk(OFS_PRIO_A, 32'h0);
    rd_chk(OFS_PRIO_B, 32'h0);
    rd_chk(8'h40, 32'h0);
    wb_cycle(1'b1, OFS_SAVED_PC, 32'hFFFFFFFF);
    rd_chk(OFS_SAVED_PC, 32'h0);
    wb_cycle(1'b1, OFS_ENABLE, 32'h0000FFFF);
    wb_cycle(1'b1, OFS_PRIO_A, 32'h00000040);
    @(posedge clk_in);
    src_req_in <= 16'h0040;
    no_accept(12);
    entry(NMI_VECTOR, 16'h0, 1'b1);
    @(posedge clk_in);
    standby_in <= 1'b1;
    nmi_in <= 1'b1;
    no_accept(12);
    entry(NMI_VECTOR, 16'h0, 1'b0);
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd18, 16'h0, 1'b0);
    check_val({30'h0, primary_mask_out, secondary_mask_out}, 32'h2);
    wb_cycle(1'b1, OFS_PRIO_A, 32'h0);
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd15, 16'h0028, 1'b0);
    l_ext = lat;
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd17, 16'h0, 1'b0);
    wb_cycle(1'b1, OFS_PRIO_B, 32'h04);
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd22, 16'h0500, 1'b0);
    check_val(32'(l_ext - lat), 32'h1);
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd20, 16'h0, 1'b0);
    wb_cycle(1'b1, OFS_ENABLE, 32'h0000FFFE);
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    @(posedge clk_in);
    src_req_in[0] <= 1'b1;
    no_accept(12);
    wb_cycle(1'b1, OFS_ENABLE, 32'h0000FFFF);
    entry(8'd12, 16'h0, 1'b0);
    wb_cycle(1'b1, OFS_SYSCTL, 32'h0);
    wb_cycle(1'b1, OFS_PRIO_A, 32'h02);
    wb_cycle(1'b1, OFS_CCR, 32'h80);
    @(posedge clk_in);
    src_req_in[2] <= 1'b1;
    no_accept(12);
    entry(8'd13, 16'h0002, 1'b0);
    check_val({30'h0, primary_mask_out, secondary_mask_out}, 32'h3);
    check_val({24'h0, saved_ccr_out}, 32'h80);
    @(posedge clk_in);
    src_req_in[1] <= 1'b1;
    no_accept(12);
    rd_chk(OFS_PEND, 32'h6);
    rd_chk(OFS_STATUS, 32'h1A01);
    rd_chk(OFS_HANDLER, 32'h4034);
    wb_cycle(1'b1, OFS_CCR, 32'h40);
    entry(8'd13, 16'h0, 1'b0);
    wb_cycle(1'b1, OFS_CCR, 32'h40);
    entry(8'd14, 16'h0, 1'b0);
    for (m = 0; m < 4; m++) begin
      s = (m == 2) ? 8 : (m == 3) ? 12 : 4;
      wb_cycle(1'b1, OFS_SYSCTL, {29'h0, m[1:0], 1'b0});
      wb_cycle(1'b1, OFS_CCR, 32'h0);
      entry(8'd21, 16'h0200, 1'b0);
      check_val(32'(cyc), 32'(6 + 3 * s + ((m != 0) ? 3 : 0)));
      check_val(32'(pf), 32'(s));
    end
    drain_len <= 8'd20;
    wb_cycle(1'b1, OFS_CCR, 32'h0);
    entry(8'd21, 16'h0200, 1'b0);
    check_val({31'h0, cyc >= 60}, 32'h1);
    wb_cycle(1'b1, OFS_PRIO_A, 32'hFF);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk(OFS_PRIO_A, 32'h0);
    check_val({31'h0, primary_mask_out}, 32'h1);
    results();
  end
endmodule
